// ---- rtl/aux_pin_defs.svh ----
// Constants for the auxiliary pin function selector
`ifndef AUX_PIN_DEFS_SVH
`define AUX_PIN_DEFS_SVH

// Pin count and function codes held in the configuration word
`define AUX_NUM_PINS       11
`define AUX_FN_PULLED_UP   4'h0
`define AUX_FN_RS485_DE    4'h1
`define AUX_FN_POWER_N     4'h2
`define AUX_FN_TX_LED_N    4'h3
`define AUX_FN_RX_LED_N    4'h4
`define AUX_FN_ANY_LED_N   4'h5
`define AUX_FN_SUSPEND_N   4'h6
`define AUX_FN_CLKOUT_30   4'h7
`define AUX_FN_CLKOUT_15   4'h8
`define AUX_FN_CLKOUT_7P5  4'h9
`define AUX_FN_DRIVE1      4'hA
`define AUX_FN_DRIVE0      4'hB
`define AUX_FN_GPIO        4'hC

// Pins that stay usable as GPIO while the UART runs (5, 6, 8, 9)
`define AUX_UART_GPIO_MASK 11'h360

// Timing: system clock, clock output rates, LED minimum pulse
`define AUX_SYS_CLK_HZ     25000000
`define AUX_CLKOUT_30_HZ   30000000
`define AUX_CLKOUT_15_HZ   15000000
`define AUX_CLKOUT_7P5_HZ  7500000
// Half periods in clk cycles; keeps the 4:2:1 ratio of the three rates
`define AUX_CLK_HALF_30    8'h01
`define AUX_CLK_HALF_15    8'h02
`define AUX_CLK_HALF_7P5   8'h04
`define AUX_LED_MIN_MS     50
`define AUX_LED_MIN_CYCLES ((`AUX_SYS_CLK_HZ / 1000) * `AUX_LED_MIN_MS)

`endif

// ---- rtl/aux_pin_pkg.sv ----
// Types shared by the auxiliary pin function selector
package aux_pin_pkg;
	`include "aux_pin_defs.svh"

	// Function selected for one auxiliary pin
	typedef enum logic [3:0] {
		FN_PULLED_UP     = `AUX_FN_PULLED_UP,
		FN_RS485_DE      = `AUX_FN_RS485_DE,
		FN_POWER_N       = `AUX_FN_POWER_N,
		FN_TX_LED_N      = `AUX_FN_TX_LED_N,
		FN_RX_LED_N      = `AUX_FN_RX_LED_N,
		FN_ANY_LED_N     = `AUX_FN_ANY_LED_N,
		FN_SUSPEND_N     = `AUX_FN_SUSPEND_N,
		FN_CLKOUT_30MHZ  = `AUX_FN_CLKOUT_30,
		FN_CLKOUT_15MHZ  = `AUX_FN_CLKOUT_15,
		FN_CLKOUT_7P5MHZ = `AUX_FN_CLKOUT_7P5,
		FN_DRIVE1        = `AUX_FN_DRIVE1,
		FN_DRIVE0        = `AUX_FN_DRIVE0,
		FN_GPIO          = `AUX_FN_GPIO
	} pin_func_t;
endpackage

// ---- rtl/activity_if.sv ----
// Activity events and stretched LED levels between selector and stretcher
`timescale 1ns/1ps
interface activity_if;
	logic tx_evt;
	logic rx_evt;
	logic tx_led_n;
	logic rx_led_n;
	logic any_led_n;

	modport src (output tx_evt, output rx_evt, input tx_led_n, input rx_led_n, input any_led_n);
	modport stretch (input tx_evt, input rx_evt, output tx_led_n, output rx_led_n,
		output any_led_n);
endinterface

// ---- rtl/activity_stretch.sv ----
// Stretches data activity pulses into visible active-low LED blinks
`timescale 1ns/1ps
`include "aux_pin_defs.svh"
module activity_stretch #(
	parameter int MIN_CYCLES = `AUX_LED_MIN_CYCLES
) (
	input  wire logic     clk,
	input  wire logic     reset,
	activity_if.stretch   act
);
	import aux_pin_pkg::*;

	localparam int CW = $clog2(MIN_CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(MIN_CYCLES);

	typedef struct packed {
		logic [CW-1:0] tx_cnt;
		logic [CW-1:0] rx_cnt;
		logic [CW-1:0] any_cnt;
		logic          tx_led_n;
		logic          rx_led_n;
		logic          any_led_n;
	} stretch_st_t;

	stretch_st_t st_q;
	stretch_st_t st_d;

	// Retrigger on event, else count down to zero
	function automatic logic [CW-1:0] next_cnt(input logic evt, input logic [CW-1:0] cnt);
		if (evt) begin
			return LOAD;
		end
		if (cnt != '0) begin
			return cnt - CW'(1);
		end
		return cnt;
	endfunction

	// LED is lit while its counter runs
	always_comb begin
		st_d           = st_q;
		st_d.tx_cnt    = next_cnt(act.tx_evt, st_q.tx_cnt);
		st_d.rx_cnt    = next_cnt(act.rx_evt, st_q.rx_cnt);
		st_d.any_cnt   = next_cnt(act.tx_evt | act.rx_evt, st_q.any_cnt);
		st_d.tx_led_n  = (st_d.tx_cnt == '0);
		st_d.rx_led_n  = (st_d.rx_cnt == '0);
		st_d.any_led_n = (st_d.any_cnt == '0);
	end

	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '{tx_cnt: '0, rx_cnt: '0, any_cnt: '0,
				tx_led_n: 1'b1, rx_led_n: 1'b1, any_led_n: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	assign act.tx_led_n  = st_q.tx_led_n;
	assign act.rx_led_n  = st_q.rx_led_n;
	assign act.any_led_n = st_q.any_led_n;
endmodule

// ---- rtl/aux_pin_function_select.sv ----
// Function selector for the eleven auxiliary control pins
`timescale 1ns/1ps
`include "aux_pin_defs.svh"
module aux_pin_function_select #(
	parameter int         NUM_PINS       = `AUX_NUM_PINS,
	parameter int         LED_MIN_CYCLES = `AUX_LED_MIN_CYCLES,
	parameter int         DIV_W          = 8,
	parameter logic [7:0] HALF_CLKOUT_30  = `AUX_CLK_HALF_30,
	parameter logic [7:0] HALF_CLKOUT_15  = `AUX_CLK_HALF_15,
	parameter logic [7:0] HALF_CLKOUT_7P5 = `AUX_CLK_HALF_7P5
) (
	input  wire logic                                clk,
	input  wire logic                                reset,
	input  wire logic                                cfg_load,
	input  aux_pin_pkg::pin_func_t [NUM_PINS-1:0]    cfg_func,
	input  wire logic                                uart_active,
	input  wire logic                                uart_tx_busy,
	input  wire logic                                tx_data_pulse,
	input  wire logic                                rx_data_pulse,
	input  wire logic                                usb_suspend,
	input  wire logic [NUM_PINS-1:0]                 gpio_dir_out,
	input  wire logic [NUM_PINS-1:0]                 gpio_out_level,
	output logic [NUM_PINS-1:0]                      gpio_in_level,
	output logic                                     cfg_loaded,
	input  wire logic [NUM_PINS-1:0]                 aux_control_pins_in,
	output logic [NUM_PINS-1:0]                      aux_control_pins_out,
	output logic [NUM_PINS-1:0]                      aux_control_pins_oe_n,
	output logic [NUM_PINS-1:0]                      aux_control_pins_pull_up
);
	import aux_pin_pkg::*;

	localparam logic [NUM_PINS-1:0] UART_GPIO = NUM_PINS'(`AUX_UART_GPIO_MASK);

	typedef struct packed {
		pin_func_t [NUM_PINS-1:0] func;
		logic                     loaded;
		logic [DIV_W-1:0]         div30;
		logic [DIV_W-1:0]         div15;
		logic [DIV_W-1:0]         div7p5;
		logic                     clkout_30mhz;
		logic                     clkout_15mhz;
		logic                     clkout_7p5mhz;
		logic [NUM_PINS-1:0]      pin_out;
		logic [NUM_PINS-1:0]      pin_oe_n;
		logic [NUM_PINS-1:0]      pin_pu;
		logic [NUM_PINS-1:0]      gpio_in;
	} sel_st_t;

	sel_st_t     st_q;
	sel_st_t     st_d;
	activity_if  act ();

	logic        rs485_drive_enable;
	logic        power_gate_n;
	logic        suspend_ind_n;

	// Divider step: count half period, report wrap
	function automatic logic [DIV_W:0] div_step(input logic [DIV_W-1:0] cnt,
		input logic [7:0] half);
		if (cnt >= DIV_W'(half) - DIV_W'(1)) begin
			return {1'b1, {DIV_W{1'b0}}};
		end
		return {1'b0, cnt + DIV_W'(1)};
	endfunction

	// Events toward the LED stretcher
	assign act.tx_evt = tx_data_pulse;
	assign act.rx_evt = rx_data_pulse;

	activity_stretch #(
		.MIN_CYCLES (LED_MIN_CYCLES)
	) u_stretch (
		.clk   (clk),
		.reset (reset),
		.act   (act)
	);

	// Fixed-function signal levels
	assign rs485_drive_enable = uart_tx_busy;
	assign power_gate_n       = usb_suspend;
	assign suspend_ind_n      = ~usb_suspend;

	// Next state: configuration, dividers and per-pin drive
	always_comb begin
		logic [DIV_W:0] s30;
		logic [DIV_W:0] s15;
		logic [DIV_W:0] s7;
		logic           gpio_ok;
		s30  = div_step(st_q.div30, HALF_CLKOUT_30);
		s15  = div_step(st_q.div15, HALF_CLKOUT_15);
		s7   = div_step(st_q.div7p5, HALF_CLKOUT_7P5);
		gpio_ok = 1'b0;
		st_d = st_q;

		// Capture the pin menu from the EEPROM load
		if (cfg_load) begin
			st_d.func   = cfg_func;
			st_d.loaded = 1'b1;
		end

		// Free-running square waves
		st_d.div30  = s30[DIV_W-1:0];
		st_d.div15  = s15[DIV_W-1:0];
		st_d.div7p5 = s7[DIV_W-1:0];
		st_d.clkout_30mhz  = st_q.clkout_30mhz ^ s30[DIV_W];
		st_d.clkout_15mhz  = st_q.clkout_15mhz ^ s15[DIV_W];
		st_d.clkout_7p5mhz = st_q.clkout_7p5mhz ^ s7[DIV_W];

		// Bit-bang input sampling
		st_d.gpio_in = aux_control_pins_in;

		for (int i = 0; i < NUM_PINS; i++) begin
			st_d.pin_out[i]  = 1'b0;
			st_d.pin_oe_n[i] = 1'b1;
			st_d.pin_pu[i]   = 1'b1;
			gpio_ok = ~uart_active | UART_GPIO[i];
			if (st_q.loaded) begin
				unique case (st_q.func[i])
				FN_PULLED_UP: begin
					st_d.pin_oe_n[i] = 1'b1;
				end
				FN_RS485_DE: begin
					st_d.pin_out[i]  = rs485_drive_enable;
					st_d.pin_oe_n[i] = 1'b0;
				end
				FN_POWER_N: begin
					st_d.pin_out[i]  = power_gate_n;
					st_d.pin_oe_n[i] = 1'b0;
				end
				FN_TX_LED_N: begin
					st_d.pin_out[i]  = act.tx_led_n;
					st_d.pin_oe_n[i] = 1'b0;
				end
				FN_RX_LED_N: begin
					st_d.pin_out[i]  = act.rx_led_n;
					st_d.pin_oe_n[i] = 1'b0;
				end
				FN_ANY_LED_N: begin
					st_d.pin_out[i]  = act.any_led_n;
					st_d.pin_oe_n[i] = 1'b0;
				end
				FN_SUSPEND_N: begin
					st_d.pin_out[i]  = suspend_ind_n;
					st_d.pin_oe_n[i] = 1'b0;
				end
				FN_CLKOUT_30MHZ: begin
					st_d.pin_out[i]  = st_q.clkout_30mhz;
					st_d.pin_oe_n[i] = 1'b0;
				end
				FN_CLKOUT_15MHZ: begin
					st_d.pin_out[i]  = st_q.clkout_15mhz;
					st_d.pin_oe_n[i] = 1'b0;
				end
				FN_CLKOUT_7P5MHZ: begin
					st_d.pin_out[i]  = st_q.clkout_7p5mhz;
					st_d.pin_oe_n[i] = 1'b0;
				end
				FN_DRIVE1: begin
					st_d.pin_out[i]  = 1'b1;
					st_d.pin_oe_n[i] = 1'b0;
					st_d.pin_pu[i]   = 1'b0;
				end
				FN_DRIVE0: begin
					st_d.pin_out[i]  = 1'b0;
					st_d.pin_oe_n[i] = 1'b0;
					st_d.pin_pu[i]   = 1'b0;
				end
				FN_GPIO: begin
					// Blocked pins fall back to pulled-up input
					if (gpio_ok && gpio_dir_out[i]) begin
						st_d.pin_out[i]  = gpio_out_level[i];
						st_d.pin_oe_n[i] = 1'b0;
						st_d.pin_pu[i]   = 1'b0;
					end
				end
				default: begin
					st_d.pin_oe_n[i] = 1'b1;
				end
				endcase
			end
			// Drivers never pull up against themselves
			if (!st_d.pin_oe_n[i]) begin
				st_d.pin_pu[i] = 1'b0;
			end
		end
	end

	// State register; every output comes from here
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '{func: '{default: FN_PULLED_UP}, loaded: 1'b0,
				div30: '0, div15: '0, div7p5: '0,
				clkout_30mhz: 1'b0, clkout_15mhz: 1'b0, clkout_7p5mhz: 1'b0,
				pin_out: '0, pin_oe_n: '1, pin_pu: '1, gpio_in: '0};
		end else begin
			st_q <= st_d;
		end
	end

	assign aux_control_pins_out     = st_q.pin_out;
	assign aux_control_pins_oe_n    = st_q.pin_oe_n;
	assign aux_control_pins_pull_up = st_q.pin_pu;
	assign gpio_in_level            = st_q.gpio_in;
	assign cfg_loaded               = st_q.loaded;
endmodule

// ---- testbench/aux_pin_assertions.sv ----
// Checker for the auxiliary pin function selector
`timescale 1ns/1ps
module aux_pin_checks
	import aux_pin_pkg::*;
#(
	parameter int NUM_PINS = 11
) (
	input wire logic                             clk,
	input wire logic                             reset,
	input wire logic                             cfg_load,
	input aux_pin_pkg::pin_func_t [NUM_PINS-1:0] cfg_func,
	input wire logic                             uart_active,
	input wire logic                             uart_tx_busy,
	input wire logic                             usb_suspend,
	input wire logic                             cfg_loaded,
	input wire logic [NUM_PINS-1:0]              gpio_in_level,
	input wire logic [NUM_PINS-1:0]              aux_control_pins_in,
	input wire logic [NUM_PINS-1:0]              aux_control_pins_out,
	input wire logic [NUM_PINS-1:0]              aux_control_pins_oe_n,
	input wire logic [NUM_PINS-1:0]              aux_control_pins_pull_up
);
	localparam logic [10:0] UART_OK = 11'h360;
	logic [NUM_PINS-1:0][3:0] fn_q;
	logic [1:0]               age_q;
	logic                     settled;
	// Copy of the loaded menu and cycles since the last load
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fn_q  <= '0;
			age_q <= 2'h0;
		end else begin
			if (cfg_load) fn_q <= cfg_func;
			age_q <= cfg_load ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
		end
	end
	assign settled = cfg_loaded && age_q == 2'h3 && !cfg_load;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_idle_before_load: assert property (!cfg_loaded |-> &aux_control_pins_oe_n &&
		&aux_control_pins_pull_up && aux_control_pins_out == '0) else $error("pins not idle");
	a_load_ack: assert property (cfg_load |=> cfg_loaded) else $error("load not acknowledged");
	a_load_sticky: assert property (cfg_loaded |=> cfg_loaded) else $error("load flag dropped");
	a_pull_released: assert property ((aux_control_pins_pull_up & ~aux_control_pins_oe_n) == '0)
		else $error("pull-up on driven pin");
	a_input_sampled: assert property (cfg_loaded && $past(cfg_loaded) |->
		gpio_in_level == $past(aux_control_pins_in)) else $error("input sample wrong");
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		a_drive_high: assert property (settled && fn_q[i] == FN_DRIVE1 |->
			!aux_control_pins_oe_n[i] && aux_control_pins_out[i]) else $error("drive1 wrong");
		a_drive_low: assert property (settled && fn_q[i] == FN_DRIVE0 |->
			!aux_control_pins_oe_n[i] && !aux_control_pins_out[i]) else $error("drive0 wrong");
		a_power_gate: assert property ((settled && fn_q[i] == FN_POWER_N &&
			$stable(usb_suspend))[*3] |-> aux_control_pins_out[i] == usb_suspend &&
			!aux_control_pins_oe_n[i]) else $error("power gate wrong");
		a_rs485_follow: assert property ((settled && fn_q[i] == FN_RS485_DE &&
			$stable(uart_tx_busy))[*3] |-> aux_control_pins_out[i] == uart_tx_busy)
			else $error("drive enable wrong");
		a_uart_blocks: assert property ((settled && uart_active && fn_q[i] == FN_GPIO &&
			!UART_OK[i])[*3] |-> aux_control_pins_oe_n[i] && aux_control_pins_pull_up[i])
			else $error("gpio not blocked");
	end
	c_reload: cover property (cfg_loaded && cfg_load);
	c_suspend: cover property (settled && $rose(usb_suspend));
	c_uart: cover property (settled && uart_active);
endmodule

bind aux_pin_function_select aux_pin_checks #(.NUM_PINS(NUM_PINS)) i_checks (
	.clk(clk), .reset(reset), .cfg_load(cfg_load), .cfg_func(cfg_func),
	.uart_active(uart_active), .uart_tx_busy(uart_tx_busy), .usb_suspend(usb_suspend),
	.cfg_loaded(cfg_loaded), .gpio_in_level(gpio_in_level),
	.aux_control_pins_in(aux_control_pins_in), .aux_control_pins_out(aux_control_pins_out),
	.aux_control_pins_oe_n(aux_control_pins_oe_n),
	.aux_control_pins_pull_up(aux_control_pins_pull_up));

// ---- testbench/aux_board_model.sv ----
// Board side of the auxiliary pins: resolves each line level
`timescale 1ns/1ps
module aux_board_model (
	input  wire logic        clk,
	input  wire logic [10:0] pin_out,
	input  wire logic [10:0] pin_oe_n,
	input  wire logic [10:0] pin_pull_up,
	input  wire logic [10:0] ext_en,
	input  wire logic [10:0] ext_val,
	output logic      [10:0] pin_level
);
	logic [10:0] float_q = '0;
	// A line nobody holds keeps wandering, so no stale value looks valid
	always_ff @(posedge clk) begin
		float_q <= ~pin_level;
	end
	// Chip drive wins, then board driver, then pull-up
	always_comb begin
		pin_level = (pin_out & ~pin_oe_n) | (ext_val & ext_en & pin_oe_n) |
			(pin_oe_n & ~ext_en & (pin_pull_up | (float_q & ~pin_pull_up)));
	end
endmodule

// ---- testbench/aux_pin_function_select_tb.sv ----
// Self-checking bench for the auxiliary pin function selector
`timescale 1ns/1ps
module aux_pin_function_select_tb;
	import aux_pin_pkg::*;
	logic             clk, reset, cfg_load, uart_active, uart_tx_busy, usb_suspend;
	logic             tx_data_pulse, rx_data_pulse, cfg_loaded;
	pin_func_t [10:0] cfg_func, cfg;
	logic [10:0]      gpio_dir_out, gpio_out_level, gpio_in_level, pins, ext_en, ext_val;
	logic [10:0]      pin_out, pin_oe_n, pin_pull_up;
	logic [2:0]       led_exp;
	int               err_count, samples_checked;
	pin_func_t        menu [11] = '{FN_RS485_DE, FN_POWER_N, FN_TX_LED_N, FN_RX_LED_N,
		FN_ANY_LED_N, FN_SUSPEND_N, FN_CLKOUT_30MHZ, FN_CLKOUT_15MHZ, FN_CLKOUT_7P5MHZ,
		FN_DRIVE1, FN_DRIVE0};

	aux_pin_function_select #(.LED_MIN_CYCLES(8), .HALF_CLKOUT_30(8'h01),
		.HALF_CLKOUT_15(8'h02), .HALF_CLKOUT_7P5(8'h04)) i_dut (
		.clk(clk), .reset(reset), .cfg_load(cfg_load), .cfg_func(cfg_func),
		.uart_active(uart_active), .uart_tx_busy(uart_tx_busy), .tx_data_pulse(tx_data_pulse),
		.rx_data_pulse(rx_data_pulse), .usb_suspend(usb_suspend), .gpio_dir_out(gpio_dir_out),
		.gpio_out_level(gpio_out_level), .gpio_in_level(gpio_in_level), .cfg_loaded(cfg_loaded),
		.aux_control_pins_in(pins), .aux_control_pins_out(pin_out),
		.aux_control_pins_oe_n(pin_oe_n), .aux_control_pins_pull_up(pin_pull_up));
	aux_board_model i_board (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_pull_up(pin_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pins));

	// Clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Inputs change one step after each rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset();
		reset = 1'b1;
		step(2);
		check(pin_oe_n & pin_pull_up, 11'h7FF);
		check(pin_out | {10'h0, cfg_loaded}, 11'h0);
		reset = 1'b0;
		step(1);
	endtask
	task automatic load(input pin_func_t [10:0] f);
		cfg_func = f;
		cfg_load = 1'b1;
		step(1);
		cfg_load = 1'b0;
		step(3);
	endtask
	// Counts pin edges over 16 cycles
	task automatic toggles(input int p, input int exp);
		int  n;
		logic last;
		n = 0;
		last = pin_out[p];
		repeat (16) begin
			step(1);
			if (pin_out[p] !== last) n++;
			last = pin_out[p];
		end
		check(11'(n), 11'(exp));
	endtask

	initial begin
		#20000;
		err_count++;
		final_report();
	end

	initial begin
		{reset, cfg_load, uart_active, uart_tx_busy, usb_suspend} = '0;
		{tx_data_pulse, rx_data_pulse, gpio_dir_out, gpio_out_level, ext_en, ext_val} = '0;
		err_count = 0;
		samples_checked = 0;
		foreach (cfg_func[i]) cfg_func[i] = FN_PULLED_UP;
		do_reset();
		foreach (cfg[i]) cfg[i] = menu[i];
		load(cfg);
		check({10'h0, cfg_loaded}, 11'h1);
		check({pin_oe_n[10:9], pin_out[10:9]}, 11'h1);
		for (int s = 0; s < 4; s++) begin
			usb_suspend = s[0];
			uart_tx_busy = s[1];
			step(3);
			check({pin_out[5], pin_out[1], pin_out[0]}, {~s[0], s[0], s[1]});
		end
		for (int k = 0; k < 3; k++) begin
			tx_data_pulse = (k != 1);
			rx_data_pulse = (k != 0);
			led_exp = {1'b0, k == 0, k == 1};
			step(1);
			{tx_data_pulse, rx_data_pulse} = 2'b00;
			step(2);
			check(pin_out[4:2], led_exp);
			step(5);
			check(pin_out[4:2], led_exp);
			step(6);
			check(pin_out[4:2], 3'h7);
		end
		toggles(6, 16);
		toggles(7, 8);
		toggles(8, 4);
		foreach (cfg[i]) cfg[i] = FN_GPIO;
		cfg[0] = FN_PULLED_UP;
		cfg[1] = pin_func_t'(4'hD);
		load(cfg);
		gpio_dir_out = 11'h7FF;
		gpio_out_level = 11'h2A8;
		step(3);
		check(pins, 11'h2AB);
		check(gpio_in_level, 11'h2AB);
		gpio_dir_out = 11'h0;
		ext_en = 11'h7FF;
		ext_val = 11'h155;
		step(3);
		check(gpio_in_level, 11'h155);
		ext_en = 11'h0;
		gpio_dir_out = 11'h7FF;
		gpio_out_level = 11'h0;
		uart_active = 1'b1;
		step(4);
		check(pins, 11'h49F);
		do_reset();
		final_report();
	end
endmodule
